// [design/aops_pkg.sv]
// package: constants and types for the converter output port strap decode
//------------------------------------------------------------------------------
// Notes on behaviour
// R1: in the fastest mode the host starts a new conversion within 1 ms of the last one.
// R2: with the serial clock inverted every serial timing refers to the opposite edge.
// R3: code-format strap high gives straight binary, low inverts the msb (twos complement).
// R4: fastest strap high, low-power strap low runs at maximum throughput with a minimum rate.
// R5: fastest strap low keeps full accuracy at any conversion rate.
// R6: low-power strap high, fastest strap low selects the reduced-power mode.
// R7: interface strap low drives the parallel port, high selects the serial port.
// R8: data bits 0 to 3 are always driven as outputs; the code leaves them undriven while reset is held.
// R9: data bit 4 is an output in parallel mode and the clock-source strap in serial mode.
// R10: clock-source low drives the internal serial clock, high follows the host clock.
// R11: data bit 5 in serial mode sets frame polarity, low active high, high active low.
// R12: data bit 6 in serial mode inverts the serial clock in master and slave modes.
// R13: on the host clock data changes on the rising edge, or falling when inverted.
// R14: results leave the serial data pin msb first from the shift register.
// R15: with the internal clock, read-mode high outputs during conversion, low after it.
// R16: both mode straps low is normal mode; both high is undefined.
//------------------------------------------------------------------------------
package aops_pkg;

    localparam int unsigned REF_CLK_MHZ  = 100;
    localparam int unsigned WARP_MAX_US  = 1000;
    localparam int unsigned WARP_MAX_CYC = WARP_MAX_US * REF_CLK_MHZ;

    localparam int unsigned WORD_W = 16;
    localparam logic [4:0]  WORD_BITS = 5'h10;
    localparam logic [1:0]  SCLK_PHASE_LAST = 2'h3;
    localparam logic [1:0]  SCLK_PHASE_RISE = 2'h2;

    // register offsets (byte addresses)
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_RESULT = 4'h4;
    localparam logic [3:0]  ADDR_STATUS = 4'h8;

    // control field positions
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;

    // data bus pin positions
    localparam int unsigned PIN_CLK_SRC = 4;
    localparam int unsigned PIN_FRM_POL = 5;
    localparam int unsigned PIN_CLK_INV = 6;
    localparam int unsigned PIN_RD_MODE = 7;
    localparam int unsigned PIN_SERIAL_RESULT_OUT   = 8;
    localparam int unsigned PIN_SCLK    = 9;

    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] OE_PARALLEL = 16'hFFFF;
    localparam logic [15:0] OE_SERIAL_SLAVE = 16'hFC0F;
    localparam logic [15:0] OE_SERIAL_MASTER = 16'hFF0F;

    typedef enum logic [1:0] {
        AOPS_MODE_NORMAL,
        AOPS_MODE_WARP,
        AOPS_MODE_IMPULSE,
        AOPS_MODE_UNDEF
    } aops_mode_t;

    // decoded strap set
    typedef struct packed {
        logic code_straight;
        logic fastest;
        logic low_power;
        logic serial;
        logic clk_external;
        logic frame_pol_low;
        logic clk_invert;
        logic read_during;
    } aops_straps_t;

    localparam int unsigned STRAP_W = 8;

endpackage

// [design/aops_top.sv]
// top: strap decode, result formatting, parallel and serial output port
module aops_top #(
    parameter int unsigned WARP_LIMIT = aops_pkg::WARP_MAX_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        sclk_ext_i,
    input  wire logic        output_code_format_select_i,
    input  wire logic        fastest_mode_i,
    input  wire logic        low_power_mode_i,
    input  wire logic        interface_kind_select_i,
    input  wire logic [15:0] data_pin_i,
    output logic      [15:0] data_pin_o,
    output logic      [15:0] data_pin_oe_o,
    output logic             serial_result_out_o,
    output logic             frame_sync_o,
    output logic             busy_o,
    output logic             low_power_o,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o
);

    //--------------------------------------------------------------------------
    // strap synchronisers
    //--------------------------------------------------------------------------
    logic [aops_pkg::STRAP_W-1:0] strap_raw;
    logic [aops_pkg::STRAP_W-1:0] strap_s1_q;
    logic [aops_pkg::STRAP_W-1:0] strap_s2_q;
    logic [aops_pkg::STRAP_W-1:0] strap_s3_q;
    logic [aops_pkg::STRAP_W-1:0] strap_q;
    aops_pkg::aops_straps_t       straps;

    assign strap_raw = {output_code_format_select_i, fastest_mode_i, low_power_mode_i,
                        interface_kind_select_i, data_pin_i[aops_pkg::PIN_CLK_SRC],
                        data_pin_i[aops_pkg::PIN_FRM_POL], data_pin_i[aops_pkg::PIN_CLK_INV],
                        data_pin_i[aops_pkg::PIN_RD_MODE]};

    for (genvar i = 0; i < aops_pkg::STRAP_W; i++)
    begin : g_strap
        always_ff @(posedge ref_clk_i)
        begin
            strap_s1_q[i] <= strap_raw[i];
            strap_s2_q[i] <= strap_s1_q[i];
            strap_s3_q[i] <= strap_s2_q[i];
            if (reset_i)
                strap_q[i] <= 1'b0;
            else if (strap_s2_q[i] == strap_s3_q[i])
                strap_q[i] <= strap_s3_q[i];
        end
    end

    assign straps = aops_pkg::aops_straps_t'(strap_q);

    //--------------------------------------------------------------------------
    // mode decode
    //--------------------------------------------------------------------------
    aops_pkg::aops_mode_t mode;
    logic                 master;

    always_comb
    begin
        unique case ({straps.fastest, straps.low_power})
            2'b10:   mode = aops_pkg::AOPS_MODE_WARP;    // R4
            2'b01:   mode = aops_pkg::AOPS_MODE_IMPULSE; // R6
            2'b00:   mode = aops_pkg::AOPS_MODE_NORMAL;  // R5 R16
            default: mode = aops_pkg::AOPS_MODE_UNDEF;   // R16
        endcase
    end

    assign master = straps.serial && !straps.clk_external; // R10

    //--------------------------------------------------------------------------
    // conversion bookkeeping and registers
    //--------------------------------------------------------------------------
    logic [15:0] raw_q;
    logic [15:0] word;
    logic        conv_q;
    logic        stale_q;
    logic [31:0] idle_cnt_q;
    logic        start_wr;
    logic        result_wr;

    assign start_wr  = reg_wr_i && reg_addr_i == aops_pkg::ADDR_CTRL
                       && reg_wdata_i[aops_pkg::CTRL_START_BIT];
    assign result_wr = reg_wr_i && reg_addr_i == aops_pkg::ADDR_RESULT;
    assign word = straps.code_straight ? raw_q : {~raw_q[15], raw_q[14:0]}; // R3

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            raw_q <= aops_pkg::RESULT_RST;
        else if (result_wr)
            raw_q <= reg_wdata_i[15:0];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            conv_q <= 1'b0;
        else if (start_wr)
            conv_q <= 1'b1;
        else if (result_wr)
            conv_q <= 1'b0;
    end

    // interval watch for the fastest mode
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || start_wr || mode != aops_pkg::AOPS_MODE_WARP)
            idle_cnt_q <= 32'h0000_0000;
        else if (idle_cnt_q < WARP_LIMIT)
            idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            stale_q <= 1'b0;
        else if (idle_cnt_q == WARP_LIMIT - 1) // R1
            stale_q <= 1'b1;
        else if (reg_wr_i && reg_addr_i == aops_pkg::ADDR_CTRL
                 && reg_wdata_i[aops_pkg::CTRL_CLEAR_BIT])
            stale_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i)
            unique case (reg_addr_i)
                aops_pkg::ADDR_RESULT: reg_rdata_o <= {16'h0000, word};
                aops_pkg::ADDR_STATUS: reg_rdata_o <= {20'h00000, stale_q, conv_q,
                                                       strap_q, mode};
                default:               reg_rdata_o <= 32'h0000_0000;
            endcase
        else
            reg_rdata_o <= 32'h0000_0000;
    end

    //--------------------------------------------------------------------------
    // master serial engine
    //--------------------------------------------------------------------------
    logic [1:0]  phase_q;
    logic [4:0]  bits_q;
    logic [15:0] mshift_q;
    logic        mstart;

    // read-mode high sends the stored word as a conversion starts
    assign mstart = master && bits_q == 5'h00
                    && (straps.read_during ? start_wr : result_wr); // R15

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            phase_q  <= 2'h0;
            bits_q   <= 5'h00;
            mshift_q <= 16'h0000;
        end
        else if (mstart)
        begin
            phase_q  <= 2'h0;
            bits_q   <= aops_pkg::WORD_BITS;
            mshift_q <= straps.read_during ? word
                        : (straps.code_straight ? reg_wdata_i[15:0]
                           : {~reg_wdata_i[15], reg_wdata_i[14:0]});
        end
        else if (bits_q != 5'h00)
        begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == aops_pkg::SCLK_PHASE_LAST)
            begin
                bits_q   <= bits_q - 5'h01;
                mshift_q <= {mshift_q[14:0], 1'b0}; // R14
            end
        end
    end

    //--------------------------------------------------------------------------
    // slave serial handover to the host clock domain
    //--------------------------------------------------------------------------
    logic [15:0] shadow_q;
    logic        req_q;
    logic        ack_s1_q;
    logic        ack_s2_q;
    logic        pending;
    logic        lack_q;

    assign pending = req_q != ack_s2_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            req_q    <= 1'b0;
            shadow_q <= 16'h0000;
        end
        else if (straps.serial && straps.clk_external && result_wr && !pending)
        begin
            req_q    <= ~req_q;
            shadow_q <= straps.code_straight ? reg_wdata_i[15:0]
                        : {~reg_wdata_i[15], reg_wdata_i[14:0]}; // R3
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        ack_s1_q <= lack_q;
        ack_s2_q <= ack_s1_q;
    end

    // host-clock side; active edge follows the inversion strap
    logic        link_clk;
    logic        lrst_s1_q;
    logic        lrst_q;
    logic        lreq_s1_q;
    logic        lreq_s2_q;
    logic [4:0]  lbits_q;
    logic [15:0] lshift_q;

    assign link_clk = sclk_ext_i ^ data_pin_i[aops_pkg::PIN_CLK_INV]; // R2 R12 R13

    always_ff @(posedge link_clk)
    begin
        lrst_s1_q <= reset_i;
        lrst_q    <= lrst_s1_q;
        lreq_s1_q <= req_q;
        lreq_s2_q <= lreq_s1_q;
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst_q)
        begin
            lack_q   <= 1'b0;
            lbits_q  <= 5'h00;
            lshift_q <= 16'h0000;
        end
        else if (lbits_q == 5'h00 && lreq_s2_q != lack_q)
        begin
            lbits_q  <= aops_pkg::WORD_BITS;
            lshift_q <= shadow_q;
        end
        else if (lbits_q != 5'h00)
        begin
            lbits_q  <= lbits_q - 5'h01;
            lshift_q <= {lshift_q[14:0], 1'b0}; // R14
            if (lbits_q == 5'h01)
                lack_q <= lreq_s2_q;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst_q)
            serial_result_out_o <= 1'b0;
        else
            serial_result_out_o <= lbits_q == 5'h00 && lreq_s2_q != lack_q
                                   ? shadow_q[15] : lshift_q[14]; // R10 R13
    end

    //--------------------------------------------------------------------------
    // pin drivers
    //--------------------------------------------------------------------------
    logic mactive;
    logic sclk_int;

    assign mactive  = bits_q != 5'h00;
    assign sclk_int = mactive && phase_q >= aops_pkg::SCLK_PHASE_RISE;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            data_pin_o    <= 16'h0000;
            data_pin_oe_o <= 16'h0000;
        end
        else if (!straps.serial)
        begin
            data_pin_o    <= word;                     // R7
            data_pin_oe_o <= aops_pkg::OE_PARALLEL;    // R9
        end
        else
        begin
            data_pin_o <= word;                                        // R8
            data_pin_o[aops_pkg::PIN_SERIAL_RESULT_OUT] <= mshift_q[15];           // R14
            data_pin_o[aops_pkg::PIN_SCLK]  <= sclk_int ^ straps.clk_invert; // R12
            data_pin_oe_o <= master ? aops_pkg::OE_SERIAL_MASTER        // R7 R9 R10
                                    : aops_pkg::OE_SERIAL_SLAVE;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            frame_sync_o <= 1'b0;
            busy_o       <= 1'b0;
            low_power_o  <= 1'b0;
        end
        else
        begin
            frame_sync_o <= straps.serial
                            && ((mactive || pending) ^ straps.frame_pol_low); // R11
            busy_o       <= conv_q;
            low_power_o  <= mode == aops_pkg::AOPS_MODE_IMPULSE;            // R6
        end
    end

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    sequence s_mstart;
        mstart;
    endsequence

    sequence s_word_out;
        mactive [*8] ##1 mactive [*8];
    endsequence

    // length of the current master word in reference cycles
    logic [6:0] mact_cnt_q;

    always_ff @(posedge ref_clk_i)
        mact_cnt_q <= (reset_i || !mactive) ? 7'h00 : mact_cnt_q + 7'h01;

    low_bits_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R8
        ##1 $past(!reset_i) |-> data_pin_oe_o[3:0] == 4'hF)
        else $error("low data bits not driven");
    par_oe_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
        !straps.serial && $stable(straps) |=> data_pin_oe_o == aops_pkg::OE_PARALLEL)
        else $error("parallel mode must drive all pins");
    strap_in_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R9
        straps.serial && $stable(straps) |=> !data_pin_oe_o[aops_pkg::PIN_CLK_SRC])
        else $error("clock-source pin driven in serial mode");
    slave_clk_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
        straps.serial && straps.clk_external && $stable(straps)
        |=> !data_pin_oe_o[aops_pkg::PIN_SCLK])
        else $error("clock pin driven while host clocks");
    fmt_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
        !straps.serial && $stable(straps) && $stable(raw_q)
        |=> data_pin_o[15] == ($past(raw_q[15]) ^ !$past(straps.code_straight)))
        else $error("msb format wrong");
    mode_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
        !straps.fastest && !straps.low_power |-> mode == aops_pkg::AOPS_MODE_NORMAL)
        else $error("normal mode not selected");
    lowpwr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
        straps.low_power && !straps.fastest |=> low_power_o)
        else $error("reduced power not flagged");
    frame_len_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R14
        s_mstart |=> s_word_out)
        else $error("serial word ended early");
    word_len_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R14
        $fell(mactive) |-> mact_cnt_q == {aops_pkg::WORD_BITS, 2'h0})
        else $error("serial word not 16 bits long");
    frame_pol_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
        straps.serial && mactive && !pending |=> frame_sync_o != $past(straps.frame_pol_low))
        else $error("frame sync polarity wrong");
    read_mode_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R15
        master && !straps.read_during && start_wr && !mactive |=> !mactive)
        else $error("data sent during conversion in read-after mode");
    stale_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
        idle_cnt_q == WARP_LIMIT - 1 |=> stale_q)
        else $error("interval overrun not flagged");

endmodule

// [sim/aops_host_model.sv]
// host model: external serial clock source and serial word reader
module aops_host_model (
    input  wire logic        inv_i,
    input  wire logic        sdata_i,
    output logic             sclk_o,
    output logic [15:0]      word_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic c;
    event got;

    // clock stands still between frames; inversion flips the pin level
    assign sclk_o = c ^ inv_i;

    initial
    begin
        c = 1'b0;
        word_o = 16'h0000;
    end

    // bare clock pulses, used to clear the serial domain during reset
    task automatic tick(input int n);
        for (int i = 0; i < n; i++)
        begin
            #16 c = 1'b1;
            #16 c = 1'b0;
        end
    endtask

    // two edges to sync the request, one bit per active edge, one edge to close
    task automatic read_word();
        for (int i = 0; i < 19; i++)
        begin
            #16 c = 1'b1;
            #16 c = 1'b0;
            if (i >= 2 && i < 18)
                word_o = {word_o[14:0], sdata_i};
        end
        ->got;
    endtask
endmodule

// [sim/aops_top_tb.sv]
// testbench: strap decode, register port, parallel and serial output checks
module aops_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned LIMIT = 50;

    logic        ref_clk_i;
    logic        reset_i;
    logic        fmt;
    logic        fast;
    logic        lp;
    logic        ser;
    logic [15:0] drv;
    logic [15:0] pins;
    logic [15:0] pin_o;
    logic [15:0] pin_oe;
    logic        sdo;
    logic        fsync;
    logic        busy;
    logic        lpo;
    logic        wr;
    logic        rd;
    logic        rd_seen;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        sclk;
    logic [15:0] hword;
    logic [15:0] w;
    logic [15:0] got;
    logic        prev;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] ser_q[$];
    logic [31:0] m_cur;
    int          error_cnt;
    int          samples_checked;
    int          n;

    // wire level from the design's enables: its output where enabled, the bench drive elsewhere
    assign pins = (pin_oe & pin_o) | (~pin_oe & drv);

    aops_top #(.WARP_LIMIT(LIMIT)) u_aops_top (
        .ref_clk_i                   (ref_clk_i),
        .reset_i                     (reset_i),
        .sclk_ext_i                  (sclk),
        .output_code_format_select_i (fmt),
        .fastest_mode_i              (fast),
        .low_power_mode_i            (lp),
        .interface_kind_select_i     (ser),
        .data_pin_i                  (pins),
        .data_pin_o                  (pin_o),
        .data_pin_oe_o               (pin_oe),
        .serial_result_out_o         (sdo),
        .frame_sync_o                (fsync),
        .busy_o                      (busy),
        .low_power_o                 (lpo),
        .reg_addr_i                  (addr),
        .reg_wdata_i                 (wdata),
        .reg_wr_i                    (wr),
        .reg_rd_i                    (rd),
        .reg_rdata_o                 (rdata)
    );

    aops_host_model u_host (
        .inv_i   (drv[6]),
        .sdata_i (sdo),
        .sclk_o  (sclk),
        .word_o  (hword)
    );

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
    endtask

    // order {fmt, fast, low power, serial, clock source, polarity, invert, read mode}
    task automatic straps(input logic [7:0] v);
        @(posedge ref_clk_i);
        {fmt, fast, lp, ser} <= v[7:4];
        drv[7:4] <= {v[0], v[1], v[2], v[3]};
        // pin straps settle only after the enables turn round
        repeat (12) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk_i) rd_seen <= rd;
    always @(negedge ref_clk_i)
        if (rd_seen === 1'b1)
        begin
            m_cur = msk_q.pop_front();
            chk(rdata & m_cur, exp_q.pop_front() & m_cur);
        end
    always @(u_host.got) chk({16'h0000, hword}, ser_q.pop_front());

    initial
    begin
        {reset_i, fmt, fast, lp, ser, wr, rd, rd_seen} = 8'h80;
        {addr, wdata} = 36'h0;
        drv = 16'h0000;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(32'hAC9C));
        u_host.tick(3);
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        drv[3:0] <= 4'($urandom);
        for (int m = 0; m < 4; m++)
        begin
            straps({1'b1, m[0], m[1], 5'h00});
            rd_reg(aops_pkg::ADDR_STATUS, 32'(m), 32'h3);
            chk({31'h0, lpo}, {31'h0, m == 2});
        end
        rd_reg(4'hC, 32'h0, 32'hFFFFFFFF);
        wr_reg(4'hC, 32'hFFFFFFFF);
        for (int f = 0; f < 2; f++)
        begin
            straps({f[0], 7'h00});
            w = 16'($urandom);
            wr_reg(aops_pkg::ADDR_RESULT, {16'h0000, w});
            rd_reg(aops_pkg::ADDR_RESULT, {16'h0000, w ^ (f ? 16'h0 : 16'h8000)}, 32'hFFFF);
            chk({16'h0, pin_oe}, 32'hFFFF);
            chk({16'h0, pin_o}, {16'h0, w ^ (f ? 16'h0 : 16'h8000)});
        end
        for (int k = 0; k < 4; k++)
        begin
            straps({4'h9, 1'b1, k[0], k[1], 1'b0});
            chk({16'h0, pin_oe}, 32'hFC0F);
            w = 16'($urandom);
            ser_q.push_back({16'h0000, w});
            wr_reg(aops_pkg::ADDR_RESULT, {16'h0000, w});
            repeat (3) @(posedge ref_clk_i);
            chk({31'h0, fsync}, {31'h0, ~k[0]});
            u_host.read_word();
            repeat (10) @(posedge ref_clk_i);
            chk({31'h0, fsync}, {31'h0, k[0]});
        end
        for (int k = 0; k < 4; k++)
        begin
            straps({4'h9, 2'b00, k[1], k[0]});
            chk({16'h0, pin_oe}, 32'hFF0F);
            w = 16'($urandom);
            if (k[0])
                wr_reg(aops_pkg::ADDR_RESULT, {16'h0000, w});
            wr_reg(aops_pkg::ADDR_CTRL, 32'h1);
            @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            chk({31'h0, fsync}, {31'h0, k[0]});
            if (!k[0])
                wr_reg(aops_pkg::ADDR_RESULT, {16'h0000, w});
            got = 16'h0000;
            prev = 1'b0;
            n = 0;
            for (int c = 0; c < 200 && n < 16; c++)
            begin
                @(negedge ref_clk_i);
                if ((pins[9] ^ k[1]) === 1'b1 && prev === 1'b0)
                begin
                    got = {got[14:0], pins[8]};
                    n++;
                end
                prev = pins[9] ^ k[1];
            end
            if (n < 16)
            begin
                error_cnt++;
                end_of_test();
            end
            chk({16'h0, got}, {16'h0, w});
            repeat (10) @(posedge ref_clk_i);
        end
        straps(8'hC0);
        wr_reg(aops_pkg::ADDR_CTRL, 32'h1);
        wr_reg(aops_pkg::ADDR_RESULT, 32'h1234);
        repeat (20) @(posedge ref_clk_i);
        wr_reg(aops_pkg::ADDR_CTRL, 32'h1);
        rd_reg(aops_pkg::ADDR_STATUS, 32'h400, 32'hC00);
        wr_reg(aops_pkg::ADDR_RESULT, 32'h4321);
        repeat (LIMIT + 10) @(posedge ref_clk_i);
        wr_reg(aops_pkg::ADDR_CTRL, 32'h1);
        rd_reg(aops_pkg::ADDR_STATUS, 32'hC00, 32'hC00);
        chk({31'h0, busy}, 32'h1);
        wr_reg(aops_pkg::ADDR_RESULT, 32'h00FF);
        repeat (2) @(negedge ref_clk_i);
        chk({31'h0, busy}, 32'h0);
        wr_reg(aops_pkg::ADDR_CTRL, 32'h2);
        rd_reg(aops_pkg::ADDR_STATUS, 32'h0, 32'hC00);
        repeat (5) @(posedge ref_clk_i);
        end_of_test();
    end
endmodule
